// >>> tcu_pkg.sv
`default_nettype none
package tcu_pkg;
  // register byte addresses on the apb bus
  localparam logic [7:0] CTRL4_OFF   = 8'h00;
  localparam logic [7:0] LOW4_OFF    = 8'h04;
  localparam logic [7:0] HIGH4_OFF   = 8'h08;
  localparam logic [7:0] CTRL5_OFF   = 8'h0C;
  localparam logic [7:0] LOW5_OFF    = 8'h10;
  localparam logic [7:0] HIGH5_OFF   = 8'h14;
  localparam logic [7:0] T3CTL_OFF   = 8'h18;
  localparam logic [7:0] STATUS_OFF  = 8'h1C;
  localparam logic [7:0] MASK_OFF    = 8'h20;
  localparam logic [7:0] PORTLAT_OFF = 8'h24;
  // field positions
  localparam int MODE_LSB  = 0;
  localparam int DUTY_LSB  = 4;
  localparam int TSEL_LO   = 3;
  localparam int TSEL_HI   = 6;
  // reset values and the control write mask
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] MATCH_RST = 8'h00;
  localparam logic [7:0] T3_RST    = 8'h00;
  localparam logic [5:0] CTRL_MASK = 6'h3F;
  // mode field codes
  typedef enum logic [3:0] {
    TCU_OFF    = 4'h0,
    TCU_TOGGLE = 4'h2,
    TCU_SET    = 4'h8,
    TCU_CLR    = 4'h9,
    TCU_SWINT  = 4'hA
  } tcu_mode_type;
endpackage
`default_nettype wire

// >>> tcu_top.sv
`default_nettype none
// Summary of operation
// - in compare mode the 16-bit match value is compared with timer one or timer three.
// - a match forces the pin high, low, toggles it, or leaves it on the port latch.
// - the match interrupt flag is set in the cycle the pin action happens.
// - software-interrupt mode leaves the pin alone and only raises an enabled interrupt.
// - writing zero to the control register forces the unit output latch low.
// - pwm mode drives a waveform with eight bits of duty resolution; the two low duty bits only round the duty up.
// - codes 0010 toggle, 1000 start low then set, 1001 start high then clear.
// - mode 0000 disables the unit and resets its internal state.
// - the timer used is chosen by the select bits in the timer three control register.

// ----------------------------------------------------------------
// one compare/pwm unit
// ----------------------------------------------------------------
module tcu_unit (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [5:0]  ctrl,
  input  wire logic        ctrl_wr,
  input  wire logic [15:0] match_val,
  input  wire logic [15:0] tmr_cnt,
  input  wire logic [7:0]  pwm_cnt,
  input  wire logic        pwm_rollover,
  input  wire logic        port_latch,
  output logic             pin_out,
  output logic             match_evt
);
  logic [3:0]  mode;
  logic [15:0] last_cnt_r;
  logic        seen_r;
  logic        out_r;
  logic        out_nxt;
  logic [9:0]  duty_r;
  logic        is_cmp;
  logic        is_pwm;
  logic        hit;
  logic        fresh;
  localparam int MODE_LSB_C = tcu_pkg::MODE_LSB;
  localparam int DUTY_LSB_C = tcu_pkg::DUTY_LSB;
  logic [9:0]  pwm_pos;
  logic        ctrl_wr_r;

  assign mode    = ctrl[MODE_LSB_C +: 4];
  assign is_cmp  = (mode == tcu_pkg::TCU_TOGGLE) || (mode == tcu_pkg::TCU_SET) ||
                   (mode == tcu_pkg::TCU_CLR) || (mode == tcu_pkg::TCU_SWINT);
  assign is_pwm  = (mode[3:2] == 2'b11);
  assign hit     = is_cmp && (tmr_cnt == match_val);
  assign fresh   = !seen_r || (last_cnt_r != tmr_cnt);
  assign match_evt = hit && fresh;
  // two sub-cycle bits are not modelled, so the low duty bits compare against zero
  assign pwm_pos = {pwm_cnt, 2'b00};

  always_comb begin
    out_nxt = out_r;
    // ctrl is the register itself, so the new code is only visible one edge after the write
    if (ctrl_wr_r) begin
      if (ctrl[3:0] == tcu_pkg::TCU_SET) begin
        out_nxt = 1'b0;
      end else if (ctrl[3:0] == tcu_pkg::TCU_CLR) begin
        out_nxt = 1'b1;
      end else if (ctrl[3:0] == tcu_pkg::TCU_OFF) begin
        out_nxt = 1'b0;
      end
    end else if (is_pwm) begin
      if (pwm_rollover) begin
        out_nxt = (duty_r != 10'h000);
      end else if (pwm_pos >= duty_r) begin
        out_nxt = 1'b0;
      end
    end else if (match_evt) begin
      unique case (mode)
        tcu_pkg::TCU_TOGGLE: out_nxt = ~out_r;
        tcu_pkg::TCU_SET:    out_nxt = 1'b1;
        tcu_pkg::TCU_CLR:    out_nxt = 1'b0;
        default:             out_nxt = out_r;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r      <= 1'b0;
      seen_r     <= 1'b0;
      last_cnt_r <= 16'h0000;
      duty_r     <= 10'h000;
      ctrl_wr_r  <= 1'b0;
    end else begin
      out_r      <= out_nxt;
      ctrl_wr_r  <= ctrl_wr;
      seen_r     <= match_evt || (seen_r && is_cmp && (last_cnt_r == tmr_cnt));
      last_cnt_r <= tmr_cnt;
      if (!is_pwm || pwm_rollover) begin
        duty_r <= {match_val[7:0], ctrl[DUTY_LSB_C +: 2]};
      end
    end
  end

  // software-interrupt mode shows the port latch
  assign pin_out = (mode == tcu_pkg::TCU_SWINT || mode == tcu_pkg::TCU_OFF) ?
                   port_latch : out_r;
endmodule

// ----------------------------------------------------------------
// top: apb slave, two units, interrupt status
// ----------------------------------------------------------------
module tcu_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] timer_one_count,
  input  wire logic [15:0] timer_three_count,
  input  wire logic [7:0]  pwm_timer_count,
  input  wire logic        pwm_period_end,
  input  wire logic        port_g_pin3_latch,
  input  wire logic        port_g_pin4_latch,
  input  wire logic [1:0]  pin_direction_bit,
  output logic             port_g_pin3_o,
  output logic             port_g_pin3_oe,
  output logic             port_g_pin4_o,
  output logic             port_g_pin4_oe,
  output logic             irq
);
  logic [5:0]  ctrl4_r;
  logic [5:0]  ctrl5_r;
  logic [15:0] mv4_r;
  logic [15:0] mv5_r;
  logic [7:0]  t3ctl_r;
  logic [1:0]  match_irq_flag_r;
  logic [1:0]  match_irq_enable_r;
  logic [1:0]  evt;
  logic        wr;
  logic        rd_ok;
  logic        wr_c4;
  logic        wr_c5;
  logic        wr_st;
  logic [1:0]  tsel;
  logic [15:0] cnt4;
  logic [15:0] cnt5;
  logic        pin4_raw;
  logic        pin5_raw;

  assign wr     = psel && penable && pwrite;
  assign wr_c4  = wr && (paddr == tcu_pkg::CTRL4_OFF);
  assign wr_c5  = wr && (paddr == tcu_pkg::CTRL5_OFF);
  assign wr_st  = wr && (paddr == tcu_pkg::STATUS_OFF);
  assign pready = 1'b1;
  assign rd_ok  = (paddr <= tcu_pkg::MASK_OFF) && (paddr[1:0] == 2'b00);
  assign pslverr = psel && penable && !rd_ok;

  // timer select from timer three control
  assign tsel = {t3ctl_r[tcu_pkg::TSEL_HI], t3ctl_r[tcu_pkg::TSEL_LO]};
  assign cnt4 = (tsel == 2'b00) ? timer_one_count : timer_three_count;
  assign cnt5 = (tsel[1] == 1'b0) ? timer_one_count : timer_three_count;

  always_comb begin
    unique case (paddr)
      tcu_pkg::CTRL4_OFF:  prdata = {26'h0, ctrl4_r};
      tcu_pkg::LOW4_OFF:   prdata = {24'h0, mv4_r[7:0]};
      tcu_pkg::HIGH4_OFF:  prdata = {24'h0, mv4_r[15:8]};
      tcu_pkg::CTRL5_OFF:  prdata = {26'h0, ctrl5_r};
      tcu_pkg::LOW5_OFF:   prdata = {24'h0, mv5_r[7:0]};
      tcu_pkg::HIGH5_OFF:  prdata = {24'h0, mv5_r[15:8]};
      tcu_pkg::T3CTL_OFF:  prdata = {24'h0, t3ctl_r};
      tcu_pkg::STATUS_OFF: prdata = {30'h0, match_irq_flag_r};
      tcu_pkg::MASK_OFF:   prdata = {30'h0, match_irq_enable_r};
      default:             prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl4_r <= tcu_pkg::CTRL_RST[5:0];
      ctrl5_r <= tcu_pkg::CTRL_RST[5:0];
      mv4_r   <= {tcu_pkg::MATCH_RST, tcu_pkg::MATCH_RST};
      mv5_r   <= {tcu_pkg::MATCH_RST, tcu_pkg::MATCH_RST};
      t3ctl_r <= tcu_pkg::T3_RST;
      match_irq_enable_r <= 2'b00;
    end else if (wr) begin
      unique case (paddr)
        tcu_pkg::CTRL4_OFF: ctrl4_r <= pwdata[5:0] & tcu_pkg::CTRL_MASK;
        tcu_pkg::LOW4_OFF:  mv4_r[7:0] <= pwdata[7:0];
        tcu_pkg::HIGH4_OFF: mv4_r[15:8] <= pwdata[7:0];
        tcu_pkg::CTRL5_OFF: ctrl5_r <= pwdata[5:0] & tcu_pkg::CTRL_MASK;
        tcu_pkg::LOW5_OFF:  mv5_r[7:0] <= pwdata[7:0];
        tcu_pkg::HIGH5_OFF: mv5_r[15:8] <= pwdata[7:0];
        tcu_pkg::T3CTL_OFF: t3ctl_r <= pwdata[7:0];
        tcu_pkg::MASK_OFF:  match_irq_enable_r <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // sticky flags: a match in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_irq_flag_r <= 2'b00;
    end else begin
      match_irq_flag_r <= (match_irq_flag_r & ~(wr_st ? pwdata[1:0] : 2'b00)) | evt;
    end
  end

  assign irq = |(match_irq_flag_r & match_irq_enable_r);

  tcu_unit u_four (
    .pclk         (pclk),
    .presetn      (presetn),
    .ctrl         (ctrl4_r),
    .ctrl_wr      (wr_c4),
    .match_val    (mv4_r),
    .tmr_cnt      (cnt4),
    .pwm_cnt      (pwm_timer_count),
    .pwm_rollover (pwm_period_end),
    .port_latch   (port_g_pin3_latch),
    .pin_out      (pin4_raw),
    .match_evt    (evt[0])
  );

  tcu_unit u_five (
    .pclk         (pclk),
    .presetn      (presetn),
    .ctrl         (ctrl5_r),
    .ctrl_wr      (wr_c5),
    .match_val    (mv5_r),
    .tmr_cnt      (cnt5),
    .pwm_cnt      (pwm_timer_count),
    .pwm_rollover (pwm_period_end),
    .port_latch   (port_g_pin4_latch),
    .pin_out      (pin5_raw),
    .match_evt    (evt[1])
  );

  // direction bit low means driven
  assign port_g_pin3_o  = pin4_raw;
  assign port_g_pin3_oe = !pin_direction_bit[0];
  assign port_g_pin4_o  = pin5_raw;
  assign port_g_pin4_oe = !pin_direction_bit[1];
endmodule
`default_nettype wire

// >>> tcu_timer_model.sv
`default_nettype none
// ----------------------------------------
// shared timer seen by both compare units
// ----------------------------------------
module tcu_timer_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load,
  input  wire logic [15:0] start_val,
  input  wire logic [15:0] stop_val,
  input  wire logic        use_three,
  output logic [15:0]      timer_one_count,
  output logic [15:0]      timer_three_count,
  output logic [7:0]       pwm_timer_count,
  output logic             pwm_period_end
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 16'h0000;
    else if (load) cnt_r <= start_val;
    else if (cnt_r != stop_val) cnt_r <= cnt_r + 16'h0001;
  end
  // unselected timer runs inverted so it never matches at the same moment
  assign timer_one_count   = use_three ? ~cnt_r : cnt_r;
  assign timer_three_count = use_three ? cnt_r : ~cnt_r;
  assign pwm_timer_count   = cnt_r[7:0];
  assign pwm_period_end    = load;
endmodule
`default_nettype wire

// >>> tcu_sva.sv
`default_nettype none
module tcu_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] timer_one_count,
  input wire logic [15:0] timer_three_count,
  input wire logic [7:0]  pwm_timer_count,
  input wire logic        pwm_period_end,
  input wire logic        port_g_pin3_latch,
  input wire logic [1:0]  pin_direction_bit,
  input wire logic        port_g_pin3_o,
  input wire logic        port_g_pin3_oe,
  input wire logic        port_g_pin4_o,
  input wire logic        port_g_pin4_oe,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mode4_r;
  wire        wr  = psel && penable && pwrite;
  wire        wr4 = wr && paddr == tcu_pkg::CTRL4_OFF;
  wire        wr5 = wr && paddr == tcu_pkg::CTRL5_OFF;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode4_r <= 4'h0;
    else if (wr4) mode4_r <= pwdata[3:0];
  end
  sequence s_quiet;
    !wr && !pwm_period_end && $stable(timer_one_count) && $stable(timer_three_count)
      && $stable(pwm_timer_count) && $stable(port_g_pin3_latch);
  endsequence
  chk_oe_follow: assert property (
    port_g_pin3_oe == !pin_direction_bit[0] && port_g_pin4_oe == !pin_direction_bit[1])
    else $error("drive enable wrong");
  chk_zero_wait: assert property (psel && penable |-> pready) else $error("late ready");
  chk_unmapped: assert property (psel && penable && paddr == 8'h40 |-> pslverr)
    else $error("no slave error");
  chk_init_high: assert property (
    wr4 && pwdata[3:0] == 4'h9 |-> ##2 port_g_pin3_o) else $error("pin not started high");
  chk_init_low: assert property (
    wr5 && pwdata[3:0] == 4'h8 |-> ##2 !port_g_pin4_o) else $error("pin not started low");
  chk_io_follow: assert property (
    mode4_r == 4'h0 || mode4_r == 4'hA |-> port_g_pin3_o == port_g_pin3_latch)
    else $error("pin not on port latch");
  chk_pin_once: assert property (
    s_quiet [*3] |-> $stable(port_g_pin3_o)) else $error("pin action repeated");
  chk_irq_once: assert property (
    s_quiet [*3] |-> $stable(irq)) else $error("irq changed while idle");
  cover property (wr4 && pwdata[3:0] == 4'h2);
  cover property ($rose(irq));
  cover property ($rose(port_g_pin4_o));
  cover property (wr4 && pwdata[3:2] == 2'b11);
endmodule
bind tcu_top tcu_sva tcu_sva_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .timer_one_count, .timer_three_count, .pwm_timer_count,
  .pwm_period_end, .port_g_pin3_latch, .pin_direction_bit, .port_g_pin3_o,
  .port_g_pin3_oe, .port_g_pin4_o, .port_g_pin4_oe, .irq);
`default_nettype wire

// >>> tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, load, use_three;
  logic        pwm_end, lat3, lat4, pin3, pin3_oe, pin4, pin4_oe, irq, lat_m;
  logic [1:0]  dir;
  logic [7:0]  paddr, pwm_cnt;
  logic [15:0] t1, t3, start_val, stop_val, v;
  logic [31:0] pwdata, prdata, q;
  int          failures, samples_checked;
  logic [3:0]  codes [$] = '{4'h2, 4'h8, 4'h2, 4'h9, 4'h2, 4'hA};
  logic [7:0]  offs [$] = '{tcu_pkg::LOW4_OFF, tcu_pkg::HIGH4_OFF, tcu_pkg::CTRL4_OFF,
    tcu_pkg::LOW5_OFF, tcu_pkg::HIGH5_OFF, tcu_pkg::CTRL5_OFF, tcu_pkg::T3CTL_OFF,
    tcu_pkg::STATUS_OFF, tcu_pkg::MASK_OFF};
  tcu_top tcu_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer_one_count(t1), .timer_three_count(t3),
    .pwm_timer_count(pwm_cnt), .pwm_period_end(pwm_end), .port_g_pin3_latch(lat3),
    .port_g_pin4_latch(lat4), .pin_direction_bit(dir), .port_g_pin3_o(pin3),
    .port_g_pin3_oe(pin3_oe), .port_g_pin4_o(pin4), .port_g_pin4_oe(pin4_oe), .irq);
  tcu_timer_model tcu_timer_model_i (.pclk, .presetn, .load, .start_val, .stop_val,
    .use_three, .timer_one_count(t1), .timer_three_count(t3), .pwm_timer_count(pwm_cnt),
    .pwm_period_end(pwm_end));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic give_verdict;
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; an idle edge after it keeps strobes from double assignment
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic rdy;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // take the answer while it stands, not in the time step of the edge that ends it
    do begin
      @(negedge pclk);
      rdy = pready;
      q = prdata;
      e = pslverr;
      @(posedge pclk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (rdy !== 1'b1) begin
      failures++;
      give_verdict();
    end
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    cmp(q, x);
  endtask
  task automatic run_to(input logic [15:0] val);
    start_val <= val - 16'h0003;
    stop_val <= val;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, load, use_three, lat3, lat4, dir} = '0;
    {paddr, pwdata, start_val, stop_val} = '0;
    void'($urandom(12958));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i]) rd(offs[i], 32'h0);
    for (int i = 0; i < 7; i++) begin
      v = 16'($urandom);
      apb(1'b1, offs[i], {16'h0, v});
      rd(offs[i], {24'h0, v[7:0] & ((i % 3 == 2) ? 8'h3F : 8'hFF)});
    end
    for (int i = 2; i < 7; i += 3) apb(1'b1, offs[i], 32'h0);
    // random select bits would steer unit four away from timer one
    apb(1'b1, tcu_pkg::T3CTL_OFF, 32'h0);
    apb(1'b1, tcu_pkg::STATUS_OFF, 32'h3);
    apb(1'b1, 8'h40, 32'h1);
    cmp(e, 1'b1);
    lat_m = 1'b0;
    foreach (codes[i]) begin
      v = 16'($urandom) | 16'h0010;
      dir <= 2'($urandom);
      lat3 <= 1'($urandom);
      apb(1'b1, tcu_pkg::LOW4_OFF, {24'h0, v[7:0]});
      apb(1'b1, tcu_pkg::HIGH4_OFF, {24'h0, v[15:8]});
      apb(1'b1, tcu_pkg::MASK_OFF, {31'h0, codes[i] == 4'hA});
      apb(1'b1, tcu_pkg::CTRL4_OFF, {28'h0, codes[i]});
      if (codes[i][3] && !codes[i][1]) begin
        lat_m = codes[i][0];
        @(posedge pclk);
        cmp(pin3, lat_m);
      end
      run_to(v);
      lat_m = (codes[i] == 4'h2) ? !lat_m : (codes[i] == 4'h8);
      cmp(pin3, (codes[i] == 4'hA) ? lat3 : lat_m);
      cmp(irq, codes[i] == 4'hA);
      rd(tcu_pkg::STATUS_OFF, 32'h1);
      apb(1'b1, tcu_pkg::STATUS_OFF, 32'h1);
      cmp(irq, 1'b0);
    end
    apb(1'b1, tcu_pkg::CTRL4_OFF, 32'h0);
    v = 16'($urandom) | 16'h0010;
    use_three <= 1'b1;
    apb(1'b1, tcu_pkg::T3CTL_OFF, 32'h48);
    apb(1'b1, tcu_pkg::LOW5_OFF, {24'h0, v[7:0]});
    apb(1'b1, tcu_pkg::HIGH5_OFF, {24'h0, v[15:8]});
    apb(1'b1, tcu_pkg::CTRL5_OFF, 32'h8);
    @(posedge pclk);
    cmp(pin4, 1'b0);
    run_to(v);
    cmp(pin4, 1'b1);
    rd(tcu_pkg::STATUS_OFF, 32'h2);
    // pwm: high from period start, low once the count reaches the duty
    v = {8'h00, 1'b0, 7'($urandom) | 7'h10};
    apb(1'b1, tcu_pkg::LOW4_OFF, {24'h0, v[7:0]});
    apb(1'b1, tcu_pkg::CTRL4_OFF, {28'h0, 2'b11, 2'($urandom)});
    run_to(v - 16'h0001);
    cmp(pin3, 1'b1);
    run_to(v);
    cmp(pin3, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
